/* wdt_pkg.sv */
// wdt_pkg: constants and types for the watchdog timer unit
// assumes a single 100 MHz clock and a 32-bit avalon-mm register slave
package wdt_pkg;

	// clock and machine cycle
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MC_CLKS_DEF = 12; // oscillator clocks per machine cycle
	localparam int TIMER_BITS_DEF = 14;
	localparam int PRESC_BITS = 8;
	localparam int RESET_MC = 2; // reset pulse, machine cycles

	// reference point: 20 mhz oscillator, shortest time-out 19.66 ms
	localparam int REF_OSC_HZ = 20_000_000;
	localparam int REF_MIN_TIMEOUT_US = 19660;
	localparam int REF_MAX_TIMEOUT_MS = 2500;

	// register word indices (byte address = index * 4)
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_INT_EN = 3'h2;
	localparam logic [2:0] ADDR_INT_CLR = 3'h3;
	localparam logic [2:0] ADDR_COUNT = 3'h4;

	// control register fields
	localparam int BIT_ENABLE = 7;
	localparam int BIT_CLEAR = 6;
	localparam int BIT_IDLE_RUN = 4;
	localparam int PS_LSB = 0;
	localparam int PS_MSB = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// event bits of status, enable and clear registers
	localparam int EV_TIMEOUT = 0;
	localparam int EV_WDT_RESET = 1;
	localparam int EV_BITS = 2;
	localparam logic [EV_BITS-1:0] EV_RESET = 2'h0;

	// control register contents
	typedef struct packed {
		logic enable;
		logic clear;
		logic idleRun;
		logic [2:0] presc;
	} ctrl_t;

	// reset pulse sequencer
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_PULSE = 2'b10
	} wdt_state_t;

endpackage

/* watchdog_timer_unit.sv */
// watchdog_timer_unit: free-running watchdog with avalon-mm registers
// assumes mclk is the oscillator, rst a synchronous system reset, and
// idleMode/powerDown come from core logic on the same clock
//
// Contract
// - free-running divider chain with selectable tap
// - time-out resets system only when enabled
// - enable bit one turns watchdog on
// - system reset leaves watchdog disabled
// - system reset zeroes count and prescaler
// - clear bit zeroes timer and prescaler
// - clear acts on next machine cycle
// - clear bit returns to zero itself
// - idle-run bit decides counting in idle
// - three-bit select divides by 2 to 256
// - time-out is 2^14 x prescale x 12 clocks
// - 20 MHz gives 19.66 ms to 2.52 s
// - idle keeps peripheral clock running
// - power-down stops all counting; a reset pulse already started still counts down to its end
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module watchdog_timer_unit #(
	parameter int MC_CLKS = wdt_pkg::MC_CLKS_DEF,
	parameter int TIMER_BITS = wdt_pkg::TIMER_BITS_DEF
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// power state of the core
	input wire logic idleMode,
	input wire logic powerDown,
	// system reset request and interrupt
	output logic wdtReset,
	output logic irq
);

	localparam int MCW = $clog2(MC_CLKS);
	localparam int RESET_CLKS = wdt_pkg::RESET_MC * MC_CLKS;
	localparam int RCW = $clog2(RESET_CLKS);

	// tap select
	// code k divides by 2^(k+1); code 001 is 4, 010 is 8
	function automatic logic [wdt_pkg::PRESC_BITS-1:0] tapMask(
		input logic [2:0] code
	);
		logic [8:0] m;
		m = (9'h002 << code) - 9'h001;
		return m[wdt_pkg::PRESC_BITS-1:0];
	endfunction

	logic [MCW-1:0] mcCnt_reg;
	logic [wdt_pkg::PRESC_BITS-1:0] prescCnt_reg;
	logic [TIMER_BITS-1:0] timerCnt_reg;
	logic [RCW-1:0] pulseCnt_reg;
	logic [RCW:0] pulseLen_reg;
	wdt_pkg::ctrl_t ctrl_reg;
	wdt_pkg::wdt_state_t state_reg;
	logic [wdt_pkg::EV_BITS-1:0] status_reg;
	logic [wdt_pkg::EV_BITS-1:0] intEn_reg;
	logic [wdt_pkg::EV_BITS-1:0] events;
	logic [wdt_pkg::EV_BITS-1:0] statusClr;
	logic [31:0] readdata_next;
	logic [2:0] addrIdx;
	logic accept;
	logic laneWr;
	logic ctrlWr;
	logic mcTick;
	logic run;
	logic prescTick;
	logic timeout;
	logic [wdt_pkg::PRESC_BITS-1:0] mask;

	// bus decode; byte lane 0 carries every writable field
	assign addrIdx = address[4:2];
	assign accept = (read || write) && !waitrequest;
	assign laneWr = accept && write && byteenable[0];
	assign ctrlWr = laneWr && addrIdx == wdt_pkg::ADDR_CTRL;

	// machine cycle strobe; oscillator stops in power-down
	// power-down freeze
	assign mcTick = !powerDown && mcCnt_reg == MCW'(MC_CLKS - 1);

	assign run = mcTick && state_reg == wdt_pkg::ST_RUN &&
		(!idleMode || ctrl_reg.idleRun);

	assign mask = tapMask(ctrl_reg.presc);

	assign prescTick = run && (prescCnt_reg & mask) == mask;

	// reference time-out
	// a clear applied at this very tick wins over the time-out
	assign timeout = prescTick && &timerCnt_reg && !ctrl_reg.clear;

	// machine cycle divider: twelve oscillator clocks each
	always_ff @(posedge mclk) begin
		if (rst) begin
			mcCnt_reg <= '0;
		end else if (!powerDown) begin
			mcCnt_reg <= mcTick ? '0 : mcCnt_reg + MCW'(1);
		end
	end

	// prescaler and 14-bit timer
	always_ff @(posedge mclk) begin
		if (rst || state_reg == wdt_pkg::ST_PULSE) begin
			prescCnt_reg <= '0;
			timerCnt_reg <= '0;
		end else if (mcTick && ctrl_reg.clear) begin
			prescCnt_reg <= '0;
			timerCnt_reg <= '0;
		end else if (run) begin
			prescCnt_reg <= prescCnt_reg + 8'h01;
			if (prescTick) begin
				timerCnt_reg <= timerCnt_reg + TIMER_BITS'(1);
			end
		end
	end

	// control register
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg <= wdt_pkg::ctrl_t'(wdt_pkg::CTRL_RESET[5:0]);
		end else if (state_reg == wdt_pkg::ST_PULSE) begin
			ctrl_reg.enable <= 1'b0;
			ctrl_reg.clear <= 1'b0;
		end else begin
			if (ctrlWr) begin
				ctrl_reg.enable <= writedata[wdt_pkg::BIT_ENABLE];
				ctrl_reg.idleRun <= writedata[wdt_pkg::BIT_IDLE_RUN];
				ctrl_reg.presc <= writedata[wdt_pkg::PS_MSB:wdt_pkg::PS_LSB];
			end
			if (ctrlWr && writedata[wdt_pkg::BIT_CLEAR]) begin
				ctrl_reg.clear <= 1'b1;
			end else if (mcTick) begin
				ctrl_reg.clear <= 1'b0;
			end
		end
	end

	// reset pulse sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= wdt_pkg::ST_RUN;
			pulseCnt_reg <= '0;
			wdtReset <= 1'b0;
		end else begin
			unique case (state_reg)
				wdt_pkg::ST_RUN: begin
					if (timeout && ctrl_reg.enable) begin
						state_reg <= wdt_pkg::ST_PULSE;
						pulseCnt_reg <= RCW'(RESET_CLKS - 1);
						wdtReset <= 1'b1;
					end
				end
				wdt_pkg::ST_PULSE: begin
					if (pulseCnt_reg == '0) begin
						state_reg <= wdt_pkg::ST_RUN;
						wdtReset <= 1'b0;
					end else begin
						pulseCnt_reg <= pulseCnt_reg - RCW'(1);
					end
				end
				default: begin
					state_reg <= wdt_pkg::ST_RUN;
					wdtReset <= 1'b0;
				end
			endcase
		end
	end

	// events: every time-out, and each reset pulse started
	always_comb begin
		events = '0;
		events[wdt_pkg::EV_TIMEOUT] = timeout;
		events[wdt_pkg::EV_WDT_RESET] = timeout && ctrl_reg.enable &&
			state_reg == wdt_pkg::ST_RUN;
	end

	assign statusClr = (laneWr && addrIdx == wdt_pkg::ADDR_INT_CLR) ?
		writedata[wdt_pkg::EV_BITS-1:0] : '0;

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_reg <= wdt_pkg::EV_RESET;
		end else begin
			status_reg <= (status_reg & ~statusClr) | events;
		end
	end

	// interrupt enable register
	always_ff @(posedge mclk) begin
		if (rst) begin
			intEn_reg <= wdt_pkg::EV_RESET;
		end else if (laneWr && addrIdx == wdt_pkg::ADDR_INT_EN) begin
			intEn_reg <= writedata[wdt_pkg::EV_BITS-1:0];
		end
	end

	// level interrupt from enabled status bits
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_reg & intEn_reg);
		end
	end

	// read multiplexer; unmapped and write-only words read zero
	always_comb begin
		readdata_next = '0;
		unique case (addrIdx)
			wdt_pkg::ADDR_CTRL: begin
				readdata_next[wdt_pkg::BIT_ENABLE] = ctrl_reg.enable;
				readdata_next[wdt_pkg::BIT_CLEAR] = ctrl_reg.clear;
				readdata_next[wdt_pkg::BIT_IDLE_RUN] = ctrl_reg.idleRun;
				readdata_next[wdt_pkg::PS_MSB:wdt_pkg::PS_LSB] = ctrl_reg.presc;
			end
			wdt_pkg::ADDR_STATUS: begin
				readdata_next[wdt_pkg::EV_BITS-1:0] = status_reg;
			end
			wdt_pkg::ADDR_INT_EN: begin
				readdata_next[wdt_pkg::EV_BITS-1:0] = intEn_reg;
			end
			wdt_pkg::ADDR_COUNT: begin
				readdata_next[TIMER_BITS-1:0] = timerCnt_reg;
			end
			default: begin
				readdata_next = '0;
			end
		endcase
	end

	// bus handshake: one wait cycle, then a single accept cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			waitrequest <= 1'b1;
			readdata <= '0;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
			readdata <= read ? readdata_next : 32'h0000_0000;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// high time of the current reset pulse, seen by pulse_len_a
	always_ff @(posedge mclk) begin
		if (rst || !wdtReset) begin
			pulseLen_reg <= '0;
		end else begin
			pulseLen_reg <= pulseLen_reg + (RCW + 1)'(1);
		end
	end

	// checks of the watchdog behaviour
	reset_disables_a: assert property (
		@(posedge mclk) rst |=> !ctrl_reg.enable && !wdtReset
	) else $error("watchdog enabled after reset");

	reset_zeroes_a: assert property (
		@(posedge mclk) rst |=> prescCnt_reg == '0 && timerCnt_reg == '0
	) else $error("count not zero after reset");

	clear_zeroes_a: assert property (
		@(posedge mclk) disable iff (rst)
		mcTick && ctrl_reg.clear && !ctrlWr |=>
			prescCnt_reg == '0 && timerCnt_reg == '0 && !ctrl_reg.clear
	) else $error("clear did not zero the chain");

	clear_self_a: assert property (
		@(posedge mclk) disable iff (rst || powerDown)
		ctrl_reg.clear && !ctrlWr |-> ##[1:12] !ctrl_reg.clear
	) else $error("clear bit stuck");

	timeout_reset_a: assert property (
		@(posedge mclk) disable iff (rst)
		timeout && ctrl_reg.enable |=> wdtReset
	) else $error("enabled time-out gave no reset");

	timeout_quiet_a: assert property (
		@(posedge mclk) disable iff (rst)
		timeout && !ctrl_reg.enable && !wdtReset |=> !wdtReset
	) else $error("disabled time-out reset the system");

	pulse_len_a: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(wdtReset) |-> pulseLen_reg == (RCW + 1)'(RESET_CLKS) &&
			!ctrl_reg.enable && timerCnt_reg == '0
	) else $error("reset pulse length wrong");

	powerdown_hold_a: assert property (
		@(posedge mclk) disable iff (rst)
		powerDown |=> $stable(timerCnt_reg) && $stable(prescCnt_reg)
	) else $error("watchdog moved in power-down");

	idle_hold_a: assert property (
		@(posedge mclk) disable iff (rst)
		idleMode && !ctrl_reg.idleRun && !ctrl_reg.clear &&
			state_reg == wdt_pkg::ST_RUN |=> $stable(timerCnt_reg)
	) else $error("watchdog counted in idle");

	tap_step_a: assert property (
		@(posedge mclk) disable iff (rst)
		prescTick && !ctrl_reg.clear && !ctrlWr |=>
			(prescCnt_reg & tapMask(ctrl_reg.presc)) == '0
	) else $error("prescaler tap misaligned");

	irq_level_a: assert property (
		@(posedge mclk) disable iff (rst)
		|(status_reg & intEn_reg) |=> irq
	) else $error("interrupt missing");

	bus_answer_a: assert property (
		@(posedge mclk) disable iff (rst)
		(read || write) && waitrequest |=> !waitrequest
	) else $error("bus request not answered");

	// main scenarios
	cov_reset_c: cover property (@(posedge mclk) $rose(wdtReset));
	cov_clear_c: cover property (@(posedge mclk)
		mcTick && ctrl_reg.clear && timerCnt_reg != '0);
	cov_idle_c: cover property (@(posedge mclk)
		idleMode && ctrl_reg.idleRun && prescTick);
	cov_irq_c: cover property (@(posedge mclk) $rose(irq));

endmodule // watchdog_timer_unit

/* test_watchdog_timer_unit.sv */
// test_watchdog_timer_unit: self-checking bench for the watchdog unit
// assumes wdt_pkg is compiled first; drives every port at the rising edge
`timescale 1ns/1ps
module test_watchdog_timer_unit;
	localparam int MC = 2; // shortened machine cycle
	localparam int TB = 3; // shortened timer width
	logic mclk, rst, read, write, idleMode, powerDown;
	logic [4:0] address;
	logic [31:0] writedata, readdata, q, q2;
	logic [3:0] byteenable;
	logic waitrequest, wdtReset, irq;
	int fail_count = 0;
	int checked = 0;
	int n, m;
	int divs [8] = '{2, 4, 8, 16, 32, 64, 128, 256}; // divisor per code

	watchdog_timer_unit #(.MC_CLKS(MC), .TIMER_BITS(TB)) u_dut (
		.mclk(mclk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.idleMode(idleMode), .powerDown(powerDown),
		.wdtReset(wdtReset), .irq(irq));

	// free-running clock, 100 MHz
	always #5 mclk = ~mclk;

	function automatic logic [4:0] ad(input logic [2:0] i);
		return {i, 2'b00};
	endfunction

	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one avalon transfer: hold until waitrequest sampled low
	task automatic bus(input logic wr, input logic [4:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge mclk);
			k++;
		end while (waitrequest !== 1'b0 && k < 100);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (k >= 100) chk(32'h0, 32'h1);
		@(posedge mclk);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog against hangs
	initial begin
		#400000;
		fail_count++;
		close_out();
	end

	initial begin
		mclk = 0; rst = 1; read = 0; write = 0; address = '0;
		writedata = '0; byteenable = 4'h1; idleMode = 0; powerDown = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		bus(0, ad(wdt_pkg::ADDR_CTRL), 0, q); chk(q, 32'h0);
		bus(0, ad(wdt_pkg::ADDR_STATUS), 0, q); chk(q, 32'h0);
		chk({31'h0, wdtReset}, 32'h0);
		// reference time-outs from the default machine cycle and width
		n = wdt_pkg::MC_CLKS_DEF * 2 * (1 << wdt_pkg::TIMER_BITS_DEF);
		m = wdt_pkg::REF_OSC_HZ / 1000;
		chk(n * 1000 / m, wdt_pkg::REF_MIN_TIMEOUT_US);
		n = n * 128 / m;
		chk(n / 100, wdt_pkg::REF_MAX_TIMEOUT_MS / 100);
		// rows: code, divisor, enabled time-out and pulse
		for (int i = 0; i < 8; i++) begin
			bus(1, ad(wdt_pkg::ADDR_CTRL), 32'hc0 | i, q);
			n = 0;
			while (wdtReset !== 1'b1 && n < 10000) begin
				@(posedge mclk);
				n++;
			end
			chk(n >= MC * divs[i] * (1 << TB) - 1 &&
				n <= MC * divs[i] * (1 << TB) + MC + 2, 1);
			m = 0;
			while (wdtReset === 1'b1 && m < 100) begin
				@(posedge mclk);
				m++;
			end
			chk(m, 2 * MC);
			bus(0, ad(wdt_pkg::ADDR_CTRL), 0, q);
			chk(q[7:6], 2'b00);
			bus(0, ad(wdt_pkg::ADDR_STATUS), 0, q); chk(q, 32'h3);
			bus(1, ad(wdt_pkg::ADDR_INT_CLR), 32'h3, q);
		end
		// time-out without enable: status only, no reset
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h40, q);
		m = 0;
		for (n = 0; n < MC * 2 * (1 << TB) + 3 * MC; n++) begin
			@(posedge mclk);
			if (wdtReset !== 1'b0) m++;
		end
		chk(m, 0);
		bus(0, ad(wdt_pkg::ADDR_STATUS), 0, q); chk(q, 32'h1);
		// interrupt raise, mask, clear
		bus(1, ad(wdt_pkg::ADDR_INT_EN), 32'h1, q);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1);
		bus(1, ad(wdt_pkg::ADDR_INT_EN), 32'h0, q);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		bus(1, ad(wdt_pkg::ADDR_INT_EN), 32'h1, q);
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h07, q);
		bus(1, ad(wdt_pkg::ADDR_INT_CLR), 32'h1, q);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		bus(0, ad(wdt_pkg::ADDR_INT_CLR), 0, q); chk(q, 32'h0);
		// clear zeroes timer and clears itself
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h40, q);
		repeat (16) @(posedge mclk);
		bus(0, ad(wdt_pkg::ADDR_COUNT), 0, q);
		chk(q != 0, 1);
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h40, q);
		repeat (MC) @(posedge mclk);
		bus(0, ad(wdt_pkg::ADDR_COUNT), 0, q);
		chk(q, 32'h0);
		repeat (2 * MC) @(posedge mclk);
		bus(0, ad(wdt_pkg::ADDR_CTRL), 0, q); chk(q[6], 1'b0);
		// free-running, idle gating, idle-run, power-down
		for (int s = 0; s < 4; s++) begin
			idleMode <= (s == 1 || s == 2);
			powerDown <= (s == 3);
			bus(1, ad(wdt_pkg::ADDR_CTRL), (s == 2) ? 32'h10 : 32'h0, q);
			bus(0, ad(wdt_pkg::ADDR_COUNT), 0, q);
			repeat (9) @(posedge mclk);
			bus(0, ad(wdt_pkg::ADDR_COUNT), 0, q2);
			chk(q2 != q, s == 0 || s == 2);
		end
		idleMode <= 1'b0;
		powerDown <= 1'b0;
		// unmapped place reads zero, write ignored
		bus(1, 5'h1c, 32'hff, q);
		bus(0, 5'h1c, 0, q); chk(q, 32'h0);
		// write without lane 0 leaves control untouched
		byteenable <= 4'h0;
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h97, q);
		byteenable <= 4'h1;
		bus(0, ad(wdt_pkg::ADDR_CTRL), 0, q); chk(q, 32'h0);
		// kicks ahead of the time-out keep the enabled watchdog quiet
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'hc0, q);
		bus(1, ad(wdt_pkg::ADDR_INT_CLR), 32'h3, q);
		m = 0;
		for (int k = 0; k < 4; k++) begin
			repeat (12) begin
				@(posedge mclk);
				if (wdtReset !== 1'b0) m++;
			end
			bus(1, ad(wdt_pkg::ADDR_CTRL), 32'hc0, q);
		end
		chk(m, 0);
		bus(0, ad(wdt_pkg::ADDR_STATUS), 0, q); chk(q, 32'h0);
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h00, q);
		// second reset while enabled
		bus(1, ad(wdt_pkg::ADDR_CTRL), 32'h87, q);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		bus(0, ad(wdt_pkg::ADDR_COUNT), 0, q); chk(q, 32'h0);
		bus(0, ad(wdt_pkg::ADDR_CTRL), 0, q); chk(q, 32'h0);
		bus(0, ad(wdt_pkg::ADDR_STATUS), 0, q); chk(q, 32'h0);
		close_out();
	end
endmodule // test_watchdog_timer_unit
